// ===== ext_ram_pkg.sv
// Shared constants for the behavioural external memory slave.
package ext_ram_pkg;

   // Default data port width in bits.
   localparam int DATA_W_DEF = 32;
   // Legal data port widths; anything else is refused at build time.
   localparam int DATA_W_8 = 8;
   localparam int DATA_W_16 = 16;
   localparam int DATA_W_32 = 32;
   localparam int DATA_W_64 = 64;
   localparam int DATA_W_128 = 128;

   // Default address width and its legal bounds.
   localparam int ADDR_W_DEF = 16;
   localparam int ADDR_W_MIN = 1;
   localparam int ADDR_W_MAX = 32;

   // Default memory size in bytes and default start offset in bytes.
   localparam int MEM_BYTES_DEF = 256;
   localparam int MEM_OFFSET_DEF = 256;

   // Write wait states: default and legal bounds.
   localparam int WR_WAIT_DEF = 2;
   localparam int WR_WAIT_MIN = 0;
   localparam int WR_WAIT_MAX = 10;
   // Width of the wait-state counter, enough for the largest count.
   localparam int WR_CNT_W = 4;

   // Read latency in clock cycles: default and legal bounds.
   localparam int RD_LAT_DEF = 3;
   localparam int RD_LAT_MIN = 1;
   localparam int RD_LAT_MAX = 255;

   // Stall outputs are raised while reset is applied.
   localparam logic STALL_RST = 1'h1;
   // Read-valid strobe is low while reset is applied.
   localparam logic OK_RST = 1'h0;

   // Write acceptance states, one-hot.
   typedef enum logic [1:0] {
      WR_HOLD = 2'h1,
      WR_OPEN = 2'h2
   } wr_state_t;

endpackage : ext_ram_pkg

// ===== read_pipe_stage.sv
`timescale 1ns/10ps
`default_nettype none

// One register stage of the read return pipeline.
module read_pipe_stage #(
   parameter int DATA_W = ext_ram_pkg::DATA_W_DEF
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic ok_in,
   input wire logic [DATA_W-1:0] data_in,
   output logic ok_out,
   output logic [DATA_W-1:0] data_out
);

   // Whole state of the stage.
   typedef struct packed {
      logic ok;
      logic [DATA_W-1:0] data;
   } stage_t;

   stage_t cur;
   stage_t next_cur;

   // The stage copies its input; reset clears both the valid bit and the data.
   always_comb begin
      next_cur.ok = ok_in;
      next_cur.data = data_in;
   end

   // Register the stage; a synchronous reset drops any data in flight.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cur <= '{ok: ext_ram_pkg::OK_RST, data: '0};
      end else begin
         cur <= next_cur;
      end
   end

   assign ok_out = cur.ok;
   assign data_out = cur.data;

endmodule : read_pipe_stage

`default_nettype wire

// ===== external_ram_slave_model.sv
`timescale 1ns/10ps
`default_nettype none

module external_ram_slave_model #(
   parameter int DATA_W = ext_ram_pkg::DATA_W_DEF,
   parameter int ADDR_W = ext_ram_pkg::ADDR_W_DEF,
   parameter int MEM_BYTES = ext_ram_pkg::MEM_BYTES_DEF,
   parameter int MEM_OFFSET = ext_ram_pkg::MEM_OFFSET_DEF,
   parameter int WR_WAIT = ext_ram_pkg::WR_WAIT_DEF,
   parameter int RD_LAT = ext_ram_pkg::RD_LAT_DEF
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic wr_req_in,
   input wire logic [ADDR_W-1:0] wr_location_in,
   input wire logic [DATA_W-1:0] wr_payload_in,
   output logic wr_stall_out,
   input wire logic rd_req_in,
   input wire logic [ADDR_W-1:0] rd_location_in,
   output logic rd_stall_out,
   output logic [DATA_W-1:0] rd_payload_out,
   output logic rd_payload_ok_out
);

   // Bytes carried by one data word, and the address bits that pick a byte.
   localparam int BPW = DATA_W / 8;
   localparam int SH = (BPW > 1) ? $clog2(BPW) : 0;
   // Number of words stored; the size is counted in bytes.
   localparam int WORDS = MEM_BYTES / BPW;
   // Width of a word index into the array.
   localparam int IDX_W = (WORDS > 1) ? $clog2(WORDS) : 1;
   // Counter value at which the last wait state ends.
   localparam logic [ext_ram_pkg::WR_CNT_W-1:0] WR_LAST =
      ext_ram_pkg::WR_CNT_W'((WR_WAIT > 0) ? WR_WAIT - 1 : 0);
   // Range bounds in a 33-bit space so a 32-bit address cannot wrap.
   localparam logic [32:0] LO = 33'(MEM_OFFSET);
   localparam logic [32:0] HI = 33'(MEM_OFFSET) + 33'(MEM_BYTES);

   // Illegal builds are refused while the design is elaborated.
   generate
      if (DATA_W != ext_ram_pkg::DATA_W_8 &&
          DATA_W != ext_ram_pkg::DATA_W_16 &&
          DATA_W != ext_ram_pkg::DATA_W_32 &&
          DATA_W != ext_ram_pkg::DATA_W_64 &&
          DATA_W != ext_ram_pkg::DATA_W_128) begin : g_bad_data_w
         $error("Data width must be 8, 16, 32, 64 or 128.");
      end
      if (ADDR_W < ext_ram_pkg::ADDR_W_MIN ||
          ADDR_W > ext_ram_pkg::ADDR_W_MAX) begin : g_bad_addr_w
         $error("Address width must lie from 1 to 32.");
      end
      if (HI >= (33'h1 << ADDR_W)) begin : g_bad_range
         $error("Size plus offset must stay below two to the n.");
      end
      if (MEM_BYTES < BPW || (MEM_BYTES % BPW) != 0) begin : g_bad_size
         $error("Size must be a whole number of data words.");
      end
      if (WR_WAIT < ext_ram_pkg::WR_WAIT_MIN ||
          WR_WAIT > ext_ram_pkg::WR_WAIT_MAX) begin : g_bad_wait
         $error("Write wait states must lie from 0 to 10.");
      end
      if (RD_LAT < ext_ram_pkg::RD_LAT_MIN ||
          RD_LAT > ext_ram_pkg::RD_LAT_MAX) begin : g_bad_lat
         $error("Read latency must lie from 1 to 255.");
      end
   endgenerate

   // Whole control state of the model.
   typedef struct packed {
      ext_ram_pkg::wr_state_t wr_state; // Write acceptance phase.
      logic [ext_ram_pkg::WR_CNT_W-1:0] wr_cnt; // Wait states served.
      logic wr_stall; // Registered write stall.
      logic rd_stall; // Registered read stall.
      logic rd_ok; // First read pipeline stage valid.
      logic [DATA_W-1:0] rd_data; // First read pipeline stage data.
   } state_t;

   state_t cur;
   state_t next_cur;

   // The storage itself; it is not cleared by reset, like a real memory.
   logic [DATA_W-1:0] mem [0:WORDS-1];

   // Decoded write and read targets.
   logic wr_hit; // Write address falls inside the range.
   logic rd_hit; // Read address falls inside the range.
   logic [IDX_W-1:0] wr_idx; // Word written.
   logic [IDX_W-1:0] rd_idx; // Word read.
   logic wr_take; // A write is completed at this edge.
   logic rd_take; // A read is accepted at this edge.

   // Map byte addresses relative to the offset onto word indexes; the
   // byte-select bits below a word are ignored, so unaligned addresses
   // land on the word that holds them.
   always_comb begin
      logic [32:0] wr_rel;
      logic [32:0] rd_rel;
      wr_rel = 33'(wr_location_in) - LO;
      rd_rel = 33'(rd_location_in) - LO;
      wr_hit = (33'(wr_location_in) >= LO) &&
               (33'(wr_location_in) < HI);
      rd_hit = (33'(rd_location_in) >= LO) &&
               (33'(rd_location_in) < HI);
      wr_idx = IDX_W'(wr_rel >> SH);
      rd_idx = IDX_W'(rd_rel >> SH);
   end

   // A write completes only on an edge where the request meets a low
   // stall; a read is refused only at the first edge after reset is released.
   assign wr_take = wr_req_in && !cur.wr_stall;
   assign rd_take = rd_req_in && !cur.rd_stall;

   // Next-state logic for write pacing and the first read stage.
   always_comb begin
      next_cur = cur;
      // Reads have a pipeline slot every cycle, so no stall is needed.
      next_cur.rd_stall = 1'h0;
      unique case (cur.wr_state)
         ext_ram_pkg::WR_HOLD: begin
            // Count wait states only while the master holds its request.
            if (!wr_req_in) begin
               next_cur.wr_cnt = '0;
            end else if (cur.wr_cnt == WR_LAST) begin
               // The last wait state ends; stay open until a write completes.
               next_cur.wr_cnt = '0;
               next_cur.wr_state = ext_ram_pkg::WR_OPEN;
               next_cur.wr_stall = 1'h0;
            end else begin
               next_cur.wr_cnt = cur.wr_cnt + 1'h1;
            end
         end
         ext_ram_pkg::WR_OPEN: begin
            // With no wait states the state stays WR_OPEN, but the stall set by reset is never
            // cleared; otherwise a completed write closes it so the next one waits again.
            if (WR_WAIT > 0 && wr_take) begin
               next_cur.wr_state = ext_ram_pkg::WR_HOLD;
               next_cur.wr_stall = 1'h1;
            end
         end
         default: begin
            // An illegal code falls back to the safe stalled phase.
            next_cur.wr_state = ext_ram_pkg::WR_HOLD;
            next_cur.wr_stall = 1'h1;
            next_cur.wr_cnt = '0;
         end
      endcase
      // First read stage: one flag per accepted read and no other.
      next_cur.rd_ok = rd_take;
      if (!rd_take || !rd_hit) begin
         // Idle cycles and reads outside the range return zero.
         next_cur.rd_data = '0;
      end else if (wr_take && wr_hit && wr_idx == rd_idx) begin
         // A write landing on the same word at the same edge is passed
         // through, so the read never sees data one write old.
         next_cur.rd_data = wr_payload_in;
      end else begin
         next_cur.rd_data = mem[rd_idx];
      end
   end

   // Register the control state; reset raises both stalls so the master
   // cannot issue anything until the model is ready.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cur.wr_state <= (WR_WAIT > 0) ? ext_ram_pkg::WR_HOLD
                                       : ext_ram_pkg::WR_OPEN;
         cur.wr_cnt <= '0;
         cur.wr_stall <= ext_ram_pkg::STALL_RST;
         cur.rd_stall <= ext_ram_pkg::STALL_RST;
         cur.rd_ok <= ext_ram_pkg::OK_RST;
         cur.rd_data <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   // Store completed writes; writes outside the range are dropped.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_in && wr_take && wr_hit) begin
         mem[wr_idx] <= wr_payload_in;
      end
   end

   // Read return pipeline: stage 0 is the state register above, and the
   // remaining latency is made up of identical register stages.
   logic stg_ok [0:RD_LAT-1];
   logic [DATA_W-1:0] stg_data [0:RD_LAT-1];

   assign stg_ok[0] = cur.rd_ok;
   assign stg_data[0] = cur.rd_data;

   generate
      genvar i;
      for (i = 1; i < RD_LAT; i++) begin : g_rd_pipe
         // Each stage adds one cycle, keeping data and flag aligned.
         read_pipe_stage #(
            .DATA_W(DATA_W)
         ) u_stage (
            .ref_clk_in(ref_clk_in),
            .rst_in(rst_in),
            .ok_in(stg_ok[i-1]),
            .data_in(stg_data[i-1]),
            .ok_out(stg_ok[i]),
            .data_out(stg_data[i])
         );
      end
   endgenerate

   // All outputs are taken directly from flip-flops.
   assign wr_stall_out = cur.wr_stall;
   assign rd_stall_out = cur.rd_stall;
   assign rd_payload_ok_out = stg_ok[RD_LAT-1];
   assign rd_payload_out = stg_data[RD_LAT-1];

endmodule : external_ram_slave_model

`default_nettype wire

// ===== ext_ram_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level checker for the external memory slave.
module ext_ram_asserts #(
   parameter int DATA_W = 32,
   parameter int ADDR_W = 16,
   parameter int WR_WAIT = 2,
   parameter int RD_LAT = 3
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic wr_req_in,
   input wire logic [ADDR_W-1:0] wr_location_in,
   input wire logic [DATA_W-1:0] wr_payload_in,
   input wire logic wr_stall_out,
   input wire logic rd_req_in,
   input wire logic [ADDR_W-1:0] rd_location_in,
   input wire logic rd_stall_out,
   input wire logic [DATA_W-1:0] rd_payload_out,
   input wire logic rd_payload_ok_out
);
   // Counts stalled cycles of a held write; a drop of the request restarts it.
   logic [4:0] wait_cnt;
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || !(wr_req_in && wr_stall_out)) begin
         wait_cnt <= 5'h0;
      end else begin
         wait_cnt <= wait_cnt + 5'h1;
      end
   end
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   sequence s_rd_take; rd_req_in && !rd_stall_out; endsequence
   sequence s_rd_back; ##RD_LAT rd_payload_ok_out; endsequence
   property p_rd_lat; s_rd_take |-> s_rd_back; endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("read answer not at its latency");
   property p_ok_cause;
      rd_payload_ok_out |-> $past(rd_req_in && !rd_stall_out, RD_LAT);
   endproperty
   a_ok_cause: assert property (p_ok_cause)
      else $error("read valid without a read");
   property p_rd_zero; !rd_payload_ok_out |-> rd_payload_out == '0; endproperty
   a_rd_zero: assert property (p_rd_zero)
      else $error("read data not zero while invalid");
   property p_rd_open; !$past(rst_in) |-> !rd_stall_out; endproperty
   a_rd_open: assert property (p_rd_open)
      else $error("read stalled outside reset");
   property p_wr_wait;
      wr_req_in && !wr_stall_out |-> wait_cnt == WR_WAIT;
   endproperty
   a_wr_wait: assert property (p_wr_wait)
      else $error("write wait count wrong");
   property p_wr_one;
      (WR_WAIT > 0) && wr_req_in && !wr_stall_out |=> wr_stall_out;
   endproperty
   a_wr_one: assert property (p_wr_one)
      else $error("write stall not raised after take");
   property p_wr_idle; (WR_WAIT > 0) && !wr_req_in |-> wr_stall_out; endproperty
   a_wr_idle: assert property (p_wr_idle)
      else $error("write stall low while idle");
   // Reset must be seen even though the other properties are off in it.
   property p_rst_vals;
      disable iff (1'b0)
      rst_in |=> wr_stall_out && rd_stall_out && !rd_payload_ok_out;
   endproperty
   a_rst_vals: assert property (p_rst_vals)
      else $error("outputs wrong during reset");
endmodule : ext_ram_asserts
`default_nettype wire

// ===== mem_master.sv
`timescale 1ns/10ps
`default_nettype none
// Bus master that holds each request until the edge that takes it.
module mem_master #(
   parameter int AW = 16,
   parameter int DW = 32
) (
   input wire logic ref_clk_in,
   output logic wr_req_out,
   output logic [AW-1:0] wr_loc_out,
   output logic [DW-1:0] wr_data_out,
   input wire logic wr_stall_in,
   output logic rd_req_out,
   output logic [AW-1:0] rd_loc_out,
   input wire logic rd_stall_in
);
   initial begin
      {wr_req_out, wr_loc_out, wr_data_out} = '0;
      {rd_req_out, rd_loc_out} = '0;
   end
   // Tasks start and end on an edge, so back-to-back calls never gap.
   task automatic write(input logic [AW-1:0] a, input logic [DW-1:0] d);
      logic st;
      #1 {wr_req_out, wr_loc_out, wr_data_out} = {1'h1, a, d};
      forever begin
         st = wr_stall_in;
         @(posedge ref_clk_in);
         if (!st) break;
         #1;
      end
   endtask : write
   task automatic read(input logic [AW-1:0] a);
      logic st;
      #1 {rd_req_out, rd_loc_out} = {1'h1, a};
      forever begin
         st = rd_stall_in;
         @(posedge ref_clk_in);
         if (!st) break;
         #1;
      end
   endtask : read
   // Released lines flip so stale values are never mistaken for live ones.
   task automatic idle();
      #1 {wr_req_out, rd_req_out} = 2'h0;
      wr_loc_out = ~wr_loc_out;
      wr_data_out = ~wr_data_out;
      rd_loc_out = ~rd_loc_out;
      @(posedge ref_clk_in);
   endtask : idle
   // Lets go of the write port alone while reads still run, so a request
   // left standing is never taken as a stray write.
   task automatic wr_release();
      #1 wr_req_out = 1'h0;
      wr_loc_out = ~wr_loc_out;
      wr_data_out = ~wr_data_out;
      @(posedge ref_clk_in);
   endtask : wr_release
endmodule : mem_master
`default_nettype wire

// ===== tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int AW = 16, DW = 32, BPW = DW / 8, RL = 3, WW = 2;
   localparam int OFF = 32'h100, SZ = 32'h100;
   logic ref_clk_in = 1'h0, rst_in = 1'h1;
   logic wr_req, wr_stall, rd_req, rd_stall, rd_ok;
   logic [AW-1:0] wr_loc, rd_loc;
   logic [DW-1:0] wr_data, rd_data;
   logic [DW-1:0] byp; // Data for the same-edge write and read.
   int seed = 32'h91C79E0A, n_mismatch = 0, n_tests = 0, cyc = 0;
   int ca[6] = '{OFF, OFF + SZ - BPW, OFF - BPW, OFF + SZ, OFF + 8, OFF + 8};
   logic [DW-1:0] shadow[int]; // Expected memory contents by word.
   logic [DW-1:0] expq[$]; // Expected read answers, oldest first.
   always #5 ref_clk_in = ~ref_clk_in;
   mem_master #(.AW(AW), .DW(DW)) M (.ref_clk_in(ref_clk_in),
      .wr_req_out(wr_req), .wr_loc_out(wr_loc), .wr_data_out(wr_data),
      .wr_stall_in(wr_stall), .rd_req_out(rd_req), .rd_loc_out(rd_loc),
      .rd_stall_in(rd_stall));
   external_ram_slave_model #(.DATA_W(DW), .ADDR_W(AW), .MEM_BYTES(SZ),
      .MEM_OFFSET(OFF), .WR_WAIT(WW), .RD_LAT(RL)) DUT (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .wr_req_in(wr_req),
      .wr_location_in(wr_loc), .wr_payload_in(wr_data),
      .wr_stall_out(wr_stall), .rd_req_in(rd_req), .rd_location_in(rd_loc),
      .rd_stall_out(rd_stall), .rd_payload_out(rd_data),
      .rd_payload_ok_out(rd_ok));
   task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done
   // Out-of-range reads answer zero; in range the word is the latest write.
   function automatic logic [DW-1:0] expect_of(input int a);
      if (a < OFF || a >= OFF + SZ) return '0;
      return shadow[(a - OFF) / BPW];
   endfunction : expect_of
   task automatic wr(input int a, input logic [DW-1:0] d);
      M.write(a[AW-1:0], d);
      if (a >= OFF && a < OFF + SZ) shadow[(a - OFF) / BPW] = d;
   endtask : wr
   task automatic rd(input int a);
      expq.push_back(expect_of(a));
      M.read(a[AW-1:0]);
   endtask : rd
   // Each valid strobe must carry the next expected word.
   always @(posedge ref_clk_in) begin
      if (!rst_in && rd_ok === 1'h1) begin
         if (expq.size() > 0) check(rd_data, expq.pop_front());
         // A strobe with nothing outstanding is always a mismatch.
         else check(DW'(rd_ok), '0);
      end
   end
   // Cuts a hang short; the whole run needs under two hundred cycles.
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         test_done();
      end
   end
   initial begin
      repeat (12) @(posedge ref_clk_in);
      #1 rst_in = 1'h0;
      @(posedge ref_clk_in);
      foreach (ca[i]) wr(ca[i], $random(seed));
      repeat (24) wr(OFF + ($random(seed) & 32'hFF), $random(seed));
      M.idle();
      // Reads run while the write port stays busy out of range; the write
      // branch lets go of its request so no stray write follows it.
      fork
         begin
            foreach (ca[i]) rd(ca[i]);
            foreach (shadow[k]) begin
               rd(OFF + k * BPW + ($random(seed) & 3));
            end
         end
         begin
            repeat (4) begin
               wr(OFF + SZ + ($random(seed) & 32'hFF),
                  $random(seed));
            end
            M.wr_release();
         end
      join
      M.idle();
      // A read taken at the very edge that completes a write to the same
      // word must already return the new data.
      byp = $random(seed);
      fork
         wr(OFF + 16, byp);
         begin
            repeat (WW) @(posedge ref_clk_in);
            expq.push_back(byp);
            M.read(AW'(OFF + 16));
         end
      join
      M.idle();
      repeat (RL + 2) @(posedge ref_clk_in);
      check(DW'(expq.size()), '0);
      test_done();
   end
endmodule : tb
bind external_ram_slave_model ext_ram_asserts #(.DATA_W(DATA_W),
   .ADDR_W(ADDR_W), .WR_WAIT(WR_WAIT), .RD_LAT(RD_LAT)) u_chk (
   .ref_clk_in(ref_clk_in), .rst_in(rst_in), .wr_req_in(wr_req_in),
   .wr_location_in(wr_location_in), .wr_payload_in(wr_payload_in),
   .wr_stall_out(wr_stall_out), .rd_req_in(rd_req_in),
   .rd_location_in(rd_location_in), .rd_stall_out(rd_stall_out),
   .rd_payload_out(rd_payload_out), .rd_payload_ok_out(rd_payload_ok_out));
`default_nettype wire
